// [logic/mcf_pkg.sv]
// Constants and types for the monitor configuration register bank
// Functional notes
// RQ1: Bits 1:0 select shared pin role
// RQ2: Disable bit blocks over-temperature output entirely
// RQ3: Output also needs enables at 0x78/0x7C/0x7D
// RQ4: Offset-64 limit of -64C disables channel
// RQ5: Twos-complement limit of -128C disables channel
// RQ6: Bit 3 clear: fans full speed on trip
// RQ7: Bit 3 set: fans capped at programmed maximum
// RQ8: Bits 7:4 bypass rail attenuators, 2.25V scale
// RQ9: Lock bit makes register read-only
// RQ10: Factory test registers read zero, read-only
// RQ11: Config register at 0x7D resets to zero
package mcf_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 3;
    localparam int NUM_FAN = 4;
    localparam int NUM_RAIL = 4;
    localparam logic [7:0] ADDR_CFG4 = 8'h7D;
    localparam logic [7:0] ADDR_TEST1 = 8'h7E;
    localparam logic [7:0] ADDR_TEST2 = 8'h7F;
    localparam logic [7:0] CFG4_RESET = 8'h00;
    localparam logic [7:0] TEST_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] FAN_FULL_DUTY = 8'hFF;
    localparam logic [7:0] LIMIT_OFF_OFS64 = 8'h00;
    localparam logic [7:0] LIMIT_OFF_TWOS = 8'h80;
    localparam int BIT_OT_OFF = 2;
    localparam int BIT_CAP = 3;
    localparam logic [1:0] ROLE_TACH = 2'h0;
    localparam logic [1:0] ROLE_OT = 2'h1;
    localparam logic [1:0] ROLE_ALERT = 2'h2;
    localparam logic [1:0] ROLE_GPIO = 2'h3;

    typedef struct packed {
        logic [3:0] bypass_divider;
        logic cap_speed_on_overtemp;
        logic overtemp_output_off;
        logic [1:0] shared_pin_role_select;
    } mcf_cfg4_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcf_bus_t;
endpackage

// [logic/mcf_ch_trip.sv]
// One temperature channel over-temperature comparator
`timescale 1ns/1ns
module mcf_ch_trip (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic twos_fmt,
    input wire logic ch_enable,
    input wire logic [7:0] temp,
    input wire logic [7:0] limit,
    output logic trip
);
    import mcf_pkg::*;
    logic disabled;
    logic over;
    always_comb begin
        disabled = twos_fmt ? (limit == LIMIT_OFF_TWOS) : (limit == LIMIT_OFF_OFS64); // [RQ4] [RQ5]
        if (twos_fmt) begin
            over = $signed(temp) > $signed(limit);
        end else begin
            over = temp > limit;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            trip <= 1'b0;
        end else begin
            trip <= ch_enable && !disabled && over; // [RQ3] [RQ4] [RQ5]
        end
    end
endmodule

// [logic/mcf_fan_drive.sv]
// One fan output duty selection
`timescale 1ns/1ns
module mcf_fan_drive (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic trip,
    input wire logic cap,
    input wire logic [7:0] auto_duty,
    input wire logic [7:0] max_duty,
    output logic [7:0] duty
);
    import mcf_pkg::*;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            duty <= 8'h00;
        end else if (trip && !cap) begin
            duty <= FAN_FULL_DUTY; // [RQ6]
        end else if (trip) begin
            duty <= max_duty; // [RQ7]
        end else begin
            duty <= auto_duty;
        end
    end
endmodule

// [logic/mcf_top.sv]
// Configuration register 4, factory test registers and over-temperature gating
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
module mcf_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire mcf_pkg::mcf_bus_t bus,
    output logic [7:0] rdata,
    input wire logic lock,
    input wire logic twos_fmt,
    input wire logic [2:0] ch_overtemp_signal_en,
    input wire logic [23:0] temps,
    input wire logic [23:0] limits,
    input wire logic [31:0] auto_duty,
    input wire logic [31:0] max_duty,
    output logic [31:0] fan_duty,
    output logic [1:0] shared_pin_role_select,
    output logic overtemp_signal,
    output logic overtemp_active_n,
    output logic smbus_alert_role,
    output logic fan_four_tach_input,
    output logic general_io_six,
    output logic [3:0] bypass_divider
);
    import mcf_pkg::*;
    mcf_cfg4_t cfg;
    logic [7:0] test1;
    logic [7:0] test2;
    logic [NUM_CH-1:0] trips;
    logic any_trip;

    // Writes to 0x7D only while unlocked; factory registers ignore writes
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg <= CFG4_RESET; // [RQ11]
        end else if (bus.wr && bus.addr == ADDR_CFG4 && !lock) begin // [RQ9]
            cfg <= bus.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            test1 <= TEST_RESET; // [RQ10]
            test2 <= TEST_RESET; // [RQ10]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata <= UNMAPPED_READ;
        end else if (bus.rd) begin
            unique case (bus.addr)
                ADDR_CFG4: rdata <= cfg;
                ADDR_TEST1: rdata <= test1; // [RQ10]
                ADDR_TEST2: rdata <= test2; // [RQ10]
                default: rdata <= UNMAPPED_READ;
            endcase
        end else begin
            rdata <= UNMAPPED_READ;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            mcf_ch_trip u_trip (
                .core_clk(core_clk),
                .nrst(nrst),
                .twos_fmt(twos_fmt),
                .ch_enable(ch_overtemp_signal_en[g]),
                .temp(temps[g*8 +: 8]),
                .limit(limits[g*8 +: 8]),
                .trip(trips[g])
            );
        end
        for (g = 0; g < NUM_FAN; g++) begin : g_fan
            mcf_fan_drive u_fan (
                .core_clk(core_clk),
                .nrst(nrst),
                .trip(any_trip),
                .cap(cfg.cap_speed_on_overtemp),
                .auto_duty(auto_duty[g*8 +: 8]),
                .max_duty(max_duty[g*8 +: 8]),
                .duty(fan_duty[g*8 +: 8])
            );
        end
    endgenerate

    assign any_trip = |trips;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            overtemp_signal <= 1'b0;
            overtemp_active_n <= 1'b1;
        end else begin
            overtemp_signal <= any_trip && !cfg.overtemp_output_off; // [RQ2] [RQ3]
            overtemp_active_n <= !(any_trip && !cfg.overtemp_output_off
                && cfg.shared_pin_role_select == ROLE_OT); // [RQ2] [RQ1]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            shared_pin_role_select <= ROLE_TACH;
            fan_four_tach_input <= 1'b1;
            smbus_alert_role <= 1'b0;
            general_io_six <= 1'b0;
            bypass_divider <= 4'h0;
        end else begin
            shared_pin_role_select <= cfg.shared_pin_role_select; // [RQ1]
            fan_four_tach_input <= cfg.shared_pin_role_select == ROLE_TACH; // [RQ1]
            smbus_alert_role <= cfg.shared_pin_role_select == ROLE_ALERT; // [RQ1]
            general_io_six <= cfg.shared_pin_role_select == ROLE_GPIO; // [RQ1]
            bypass_divider <= cfg.bypass_divider; // [RQ8]
        end
    end

    sequence s_pin_trip;
        any_trip && !cfg.overtemp_output_off && cfg.shared_pin_role_select == ROLE_OT;
    endsequence

    sequence s_idle_bus;
        !bus.rd;
    endsequence

    AST_PIN_DRIVE: assert property (@(posedge core_clk) disable iff (!nrst)
        s_pin_trip |=> !overtemp_active_n) else $error("overtemp pin not driven"); // [RQ1]
    AST_PIN_QUIET: assert property (@(posedge core_clk) disable iff (!nrst)
        cfg.shared_pin_role_select != ROLE_OT |=> overtemp_active_n) else $error("pin driven in other role"); // [RQ1]
    AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
        s_idle_bus |=> rdata == UNMAPPED_READ) else $error("read data outside read cycle"); // [RQ10]

    sequence s_locked_write;
        lock && bus.wr && bus.addr == ADDR_CFG4;
    endsequence

    AST_LOCK_HOLDS: assert property (@(posedge core_clk) disable iff (!nrst)
        s_locked_write |=> $stable(cfg)) else $error("locked write changed config"); // [RQ9]
    AST_OT_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
        cfg.overtemp_output_off |=> !overtemp_signal) else $error("overtemp asserted while disabled"); // [RQ2]
    AST_FULL_SPEED: assert property (@(posedge core_clk) disable iff (!nrst)
        any_trip && !cfg.cap_speed_on_overtemp |=> fan_duty[7:0] == FAN_FULL_DUTY)
        else $error("fan not full on trip"); // [RQ6]
    AST_CAP_SPEED: assert property (@(posedge core_clk) disable iff (!nrst)
        any_trip && cfg.cap_speed_on_overtemp |=> fan_duty[7:0] == $past(max_duty[7:0]))
        else $error("fan not capped on trip"); // [RQ7]
    AST_TEST_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
        bus.rd && bus.addr == ADDR_TEST1 |=> rdata == TEST_RESET) else $error("test reg nonzero"); // [RQ10]
    AST_ROLE: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 shared_pin_role_select == $past(cfg.shared_pin_role_select)) else $error("role mismatch"); // [RQ1]
    AST_BYPASS: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 bypass_divider == $past(cfg.bypass_divider)) else $error("bypass mismatch"); // [RQ8]
    AST_RESET_CFG: assert property (@(posedge core_clk)
        !nrst |=> cfg == CFG4_RESET) else $error("config not reset"); // [RQ11]
    AST_CH_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
        ch_overtemp_signal_en == 3'h0 |=> trips == 3'h0) else $error("trip without channel enable"); // [RQ3]
endmodule

// [sim/test_monitor_config_four_regs.sv]
// Self-checking bench for the configuration register and over-temperature gating
`timescale 1ns/1ns
module test_monitor_config_four_regs;
    import mcf_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    mcf_bus_t bus = '0;
    logic lock = 1'b0;
    logic twos_fmt = 1'b0;
    logic [2:0] ch_overtemp_signal_en = 3'h7;
    logic [23:0] temps = 24'h00_0000;
    logic [23:0] limits = 24'hff_ffff;
    logic [31:0] auto_duty = 32'h0000_0000;
    logic [31:0] max_duty = 32'h0000_0000;
    logic [31:0] fan_duty;
    logic [7:0] rdata;
    logic [1:0] role;
    logic [3:0] bypass;
    logic ot, ot_n, alert, tach, gpio;
    logic [7:0] cfg = 8'h00;
    logic [7:0] d;
    logic [31:0] r;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 32'h8c3c;

    mcf_top dut (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .lock(lock), .twos_fmt(twos_fmt),
        .ch_overtemp_signal_en(ch_overtemp_signal_en), .temps(temps), .limits(limits), .auto_duty(auto_duty), .max_duty(max_duty),
        .fan_duty(fan_duty), .shared_pin_role_select(role), .overtemp_signal(ot), .overtemp_active_n(ot_n),
        .smbus_alert_role(alert), .fan_four_tach_input(tach), .general_io_six(gpio), .bypass_divider(bypass));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge core_clk);
        bus <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        bus <= '0;
        #1 check("rdata", {24'h0, rdata}, {24'h0, exp});
    endtask

    // Model of trip detection, pin decode and fan duty selection
    task automatic check_out();
        logic [7:0] t, l;
        logic hot;
        repeat (4) @(posedge core_clk);
        #1 hot = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            t = temps[c*8 +: 8];
            l = limits[c*8 +: 8];
            if (ch_overtemp_signal_en[c] && l !== (twos_fmt ? LIMIT_OFF_TWOS : LIMIT_OFF_OFS64)
                && (twos_fmt ? $signed(t) > $signed(l) : t > l)) begin
                hot = 1'b1;
            end
        end
        check("overtemp_signal", {31'h0, ot}, {31'h0, hot && !cfg[2]});
        check("overtemp_active_n", {31'h0, ot_n}, {31'h0, !(hot && !cfg[2] && cfg[1:0] == 2'h1)});
        check("role", {25'h0, role, tach, alert, gpio}, {25'h0, cfg[1:0], cfg[1:0] == 2'h0, cfg[1:0] == 2'h2,
            cfg[1:0] == 2'h3});
        check("bypass", {28'h0, bypass}, {28'h0, cfg[7:4]});
        check("fan_duty", fan_duty, hot ? (cfg[3] ? max_duty : {4{FAN_FULL_DUTY}}) : auto_duty);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        rd_chk(ADDR_CFG4, 8'h00);
        rd_chk(ADDR_TEST1, 8'h00);
        rd_chk(ADDR_TEST2, 8'h00);
        check_out();
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            d = {r[7:4], i[3:0]};
            wr(ADDR_CFG4, d);
            cfg = d;
            rd_chk(ADDR_CFG4, cfg);
            @(posedge core_clk);
            twos_fmt <= i[0];
            r = $random(seed);
            ch_overtemp_signal_en <= r[2:0];
            r = $random(seed);
            temps <= r[23:0];
            r = $random(seed);
            limits <= r[23:0];
            r = $random(seed);
            auto_duty <= r;
            r = $random(seed);
            max_duty <= r;
            check_out();
            @(posedge core_clk);
            ch_overtemp_signal_en <= 3'h7;
            temps <= 24'h70_7070;
            limits <= i[0] ? {16'h7f7f, LIMIT_OFF_TWOS} : {16'hffff, LIMIT_OFF_OFS64};
            check_out();
            @(posedge core_clk);
            limits <= 24'h10_1010;
            check_out();
        end
        $display("test config sweep done");
        @(posedge core_clk);
        lock <= 1'b1;
        wr(ADDR_CFG4, ~cfg);
        rd_chk(ADDR_CFG4, cfg);
        check_out();
        @(posedge core_clk);
        lock <= 1'b0;
        $display("test lock done");
        wr(ADDR_TEST1, 8'ha5);
        wr(ADDR_TEST2, 8'h5a);
        rd_chk(ADDR_TEST1, TEST_RESET);
        rd_chk(ADDR_TEST2, TEST_RESET);
        rd_chk(8'h10, UNMAPPED_READ);
        $display("test reserved done");
        finish_test();
    end
endmodule
